// ---- raster_op_datapath_tb.sv ----
// Testbench: controller and datapath joined by the link, driven from the command port.
`timescale 1ns/1ps
`default_nettype none
module raster_op_datapath_tb;
  logic              clk = 1'b0;
  logic              srst = 1'b1;
  logic              start = 1'b0;
  logic              rtl = 1'b0;
  rop_pkg::rop_cmd_t cmd = rop_pkg::ROP_CMD_SEQ1;
  logic [15:0]       cw = 16'h000f;
  logic [15:0]       src = 16'hc3a5;
  logic [15:0]       dst = 16'h5a0f;
  logic [4:0]        nw = 5'h01;
  logic              busy;
  logic              result_valid;
  logic [15:0]       result;
  logic [15:0]       control_word;
  logic [4:0]        fifo_count;
  logic [15:0]       res [0:31];
  int                n_errors = 0;
  int                comparisons = 0;
  int                nres;

  // =====================================================================
  // Clock and the two ends.
  always #25 clk = ~clk;
  rop_link_if rop_link_if_i ();
  rop_datapath rop_datapath_i (.clk(clk), .srst(srst), .link(rop_link_if_i.dev),
    .fifo_count(fifo_count), .control_word(control_word));
  rop_controller rop_controller_i (.clk(clk), .srst(srst), .start(start), .cmd(cmd),
    .ctrl_word(cw), .n_words(nw), .right_to_left(rtl), .src_data(src), .dst_data(dst),
    .busy(busy), .result_valid(result_valid), .result(result), .link(rop_link_if_i.ctl));
  rop_link_checker rop_link_checker_i (.clk(clk), .srst(srst),
    .dq_ctl(rop_link_if_i.dq_ctl), .dq_ctl_oe(rop_link_if_i.dq_ctl_oe),
    .dq_dev_oe(rop_link_if_i.dq_dev_oe),
    .control_load_strobe(rop_link_if_i.control_load_strobe),
    .data_latch_en(rop_link_if_i.data_latch_en), .line_mode(rop_link_if_i.line_mode),
    .pixel_address_lines(rop_link_if_i.pixel_address_lines),
    .fifo_clear(rop_link_if_i.fifo_clear), .fifo_count(fifo_count),
    .control_word(control_word));

  // =====================================================================
  // Reference model and checking tasks.
  // Expected written word: function per bit, then merge with destination by both masks.
  function automatic logic [15:0] expect_word(input logic [15:0] w, input logic [15:0] s);
    logic [15:0] r;
    logic [15:0] m;
    for (int b = 0; b < 16; b++) r[b] = w[12 + {s[b], dst[b]}];
    m = (16'hffff >> w[7:4]) & ~(16'hffff >> ({1'b0, w[3:0]} + 5'h01));
    return (r & m) | (dst & ~m);
  endfunction
  // Shifter output when both input latches hold the same word.
  function automatic logic [15:0] rotl(input logic [15:0] s, input logic [3:0] i);
    return (s << i) | (s >> (5'h10 - {1'b0, i}));
  endfunction
  task automatic chk16(input string what, input logic [15:0] exp, input logic [15:0] got);
    comparisons++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic chk1(input string what, input logic exp, input logic got);
    comparisons++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic chk5(input string what, input logic [4:0] exp, input logic [4:0] got);
    comparisons++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic test_done;
    $display("Comparisons %0d, mismatches %0d", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  // One command: pulse start, collect every result until busy drops, bounded.
  task automatic run(input rop_pkg::rop_cmd_t c, input logic [15:0] w, input logic [4:0] n);
    @(posedge clk);
    cmd <= c;
    cw <= w;
    nw <= n;
    start <= 1'b1;
    @(posedge clk);
    start <= 1'b0;
    nres = 0;
    for (int k = 0; k <= 3000; k++) begin
      @(posedge clk);
      #1;
      if (result_valid === 1'b1 && nres < 32) begin
        res[nres] = result;
        nres++;
      end
      if (busy === 1'b0) break;
      if (k == 3000) begin
        n_errors++;
        $display("CHECK FAILED busy expected 0 seen 1");
        test_done();
      end
    end
  endtask

  // =====================================================================
  // Main sequence. The source word stays constant so both shifter latches agree.
  initial begin
    repeat (8) @(posedge clk);
    srst <= 1'b0;
    run(rop_pkg::ROP_CMD_SEQ1, 16'h000f, 5'h02);
    for (int f = 0; f < 16; f++) begin
      run(rop_pkg::ROP_CMD_SEQ1, {f[3:0], 12'h00f}, 5'h01);
      chk5("word count", 5'h01, nres[4:0]);
      chk16("control", {f[3:0], 12'h00f}, control_word);
      chk16("function", expect_word({f[3:0], 12'h00f}, src), res[0]);
    end
    $display("Function test done");
    for (int k = 0; k < 32; k++) begin
      run(rop_pkg::ROP_CMD_SEQ1, {8'hf0, k[3:0], k[4] ? k[3:0] : 4'hf - k[3:0]}, 5'h01);
      chk16("mask", expect_word({8'hf0, k[3:0], k[4] ? k[3:0] : 4'hf - k[3:0]}, src), res[0]);
    end
    $display("Mask test done");
    for (int k = 0; k < 32; k++) begin
      rtl <= k[4];
      run(rop_pkg::ROP_CMD_SEQ1, {4'hc, k[3:0], 8'h0f}, 5'h02);
      chk16("shift", rotl(src, k[3:0]), res[1]);
    end
    rtl <= 1'b0;
    $display("Shift test done");
    run(rop_pkg::ROP_CMD_SEQ1, 16'hc50f, 5'h10);
    chk5("burst count", 5'h10, nres[4:0]);
    for (int k = 0; k < 16; k++) chk16("burst", rotl(src, 4'h5), res[k]);
    run(rop_pkg::ROP_CMD_SEQ2, 16'h600f, 5'h10);
    chk5("seq2 count", 5'h10, nres[4:0]);
    for (int k = 0; k < 16; k++) chk16("seq2", src ^ dst, res[k]);
    chk5("fifo drained", 5'h00, fifo_count);
    $display("Sequence test done");
    // Three operands as two serial passes: AND first, then XOR with the source again.
    run(rop_pkg::ROP_CMD_SEQ1, 16'h800f, 5'h01);
    chk16("pass one", src & dst, res[0]);
    dst <= res[0];
    run(rop_pkg::ROP_CMD_SEQ1, 16'h600f, 5'h01);
    chk16("pass two", src ^ (src & 16'h5a0f), res[0]);
    dst <= 16'h5a0f;
    $display("Two pass test done");
    // Line mode: pixel operand replicated, pixel pin picks one result bit.
    for (int k = 0; k < 16; k++) begin
      run(rop_pkg::ROP_CMD_LINE, {4'h6, 8'h00, k[3:0]}, 5'h01);
      chk16("line word", expect_word(16'h600f, {16{src[15]}}), res[0]);
      chk1("pixel", src[15] ^ dst[k], rop_link_if_i.pixel_data_pin);
    end
    $display("Line test done");
    // Reset in mid-transfer must bring back the idle state.
    @(posedge clk);
    cmd <= rop_pkg::ROP_CMD_SEQ2;
    cw <= 16'h6a5f;
    nw <= 5'h10;
    start <= 1'b1;
    @(posedge clk);
    start <= 1'b0;
    repeat (20) @(posedge clk);
    srst <= 1'b1;
    @(posedge clk);
    srst <= 1'b0;
    @(posedge clk);
    #1;
    chk16("control reset", 16'h000f, control_word);
    chk5("fifo reset", 5'h00, fifo_count);
    chk1("busy reset", 1'b0, busy);
    $display("Reset test done");
    test_done();
  end
endmodule // raster_op_datapath_tb
`default_nettype wire

// ---- rop_cfg.svh ----
// Constants for the raster operation datapath: field positions, codes and sizes.
`ifndef ROP_CFG_SVH
`define ROP_CFG_SVH

// =====================================================================
// Control word field positions (most to least significant nibble).
`define ROP_FS_MSB      15
`define ROP_FS_LSB      12
`define ROP_SN_MSB      11
`define ROP_SN_LSB      8
`define ROP_LM_MSB      7
`define ROP_LM_LSB      4
`define ROP_RM_MSB      3
`define ROP_RM_LSB      0

// =====================================================================
// Reset values and sizes.
`define ROP_CTRL_RESET  16'h000f
`define ROP_WORD_W      16
`define ROP_FIFO_DEPTH  16

// =====================================================================
// Function select codes; the controller does not reference them.
`define ROP_FN_ZERO     4'h0
`define ROP_FN_XOR      4'h6
`define ROP_FN_SRC      4'hc
`define ROP_FN_ONE      4'hf

`endif

// ---- rop_controller.sv ----
// Controller end: drives one block-transfer line through the datapath.
`timescale 1ns/1ps
`default_nettype none
`include "rop_cfg.svh"

module rop_controller (
  // Clock and reset.
  input  wire logic                 clk,
  input  wire logic                 srst,
  // Command port from the user.
  input  wire logic                 start,
  input  wire rop_pkg::rop_cmd_t    cmd,
  input  wire logic [15:0]          ctrl_word,
  input  wire logic [4:0]           n_words,
  input  wire logic                 right_to_left,
  input  wire logic [15:0]          src_data,
  input  wire logic [15:0]          dst_data,
  // Results and status.
  output logic                      busy,
  output logic                      result_valid,
  output logic [15:0]               result,
  // Link to the datapath.
  rop_link_if.ctl                   link
);
  typedef enum logic [2:0] {ST_IDLE, ST_CTRL, ST_SRC, ST_DST, ST_OUT, ST_DONE} rop_st_t;
  rop_st_t   st, next_st;
  logic [4:0] cnt, next_cnt;
  logic [15:0] res, next_res;
  logic       rv, next_rv;
  logic [2:0] wait_c, next_wait_c;
  logic       src_d1, next_src_d1;
  logic       src_d2, next_src_d2;
  logic       last_word;

  // Last word of the line or of a sixteen-word group.
  assign last_word = cnt + 5'h01 >= n_words || cnt == 5'h0f;

  // Sequencer: control load, source burst, destination pass, optional drain.
  always_comb begin
    next_st = st;
    next_cnt = cnt;
    next_res = res;
    next_rv = 1'b0;
    next_wait_c = 3'h0;
    // A shifted word only reaches the shifter two cycles after its bus word is latched.
    next_src_d1 = st == ST_SRC;
    next_src_d2 = src_d1;
    case (st)
      ST_IDLE: if (start) next_st = ST_CTRL;
      ST_CTRL: begin next_st = ST_SRC; next_cnt = 5'h00; end
      ST_SRC: begin
        // Stop after the line or sixteen words, whichever first.
        if (cnt + 5'h01 >= n_words || cnt == 5'h0f) begin
          next_st = ST_DST;
          next_cnt = 5'h00;
        end else next_cnt = cnt + 5'h01;
      end
      ST_DST: begin
        next_wait_c = wait_c + 3'h1;
        if (wait_c == 3'h3) begin
          next_rv = cmd != rop_pkg::ROP_CMD_SEQ2;
          next_res = link.dq_dev;
          next_wait_c = 3'h0;
          if (cnt + 5'h01 >= n_words || cnt == 5'h0f) begin
            next_st = cmd == rop_pkg::ROP_CMD_SEQ2 ? ST_OUT : ST_DONE;
            next_cnt = 5'h00;
          end else next_cnt = cnt + 5'h01;
        end
      end
      ST_OUT: begin
        next_wait_c = wait_c + 3'h1;
        if (wait_c == 3'h1) begin
          next_rv = 1'b1;
          next_res = link.dq_dev;
          next_wait_c = 3'h0;
          if (cnt + 5'h01 >= n_words || cnt == 5'h0f) next_st = ST_DONE;
          else next_cnt = cnt + 5'h01;
        end
      end
      ST_DONE: next_st = ST_IDLE;
      default: next_st = ST_IDLE;
    endcase
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      st <= ST_IDLE;
      cnt <= 5'h00;
      res <= 16'h0000;
      rv <= 1'b0;
      wait_c <= 3'h0;
      src_d1 <= 1'b0;
      src_d2 <= 1'b0;
    end else begin
      st <= next_st;
      cnt <= next_cnt;
      res <= next_res;
      rv <= next_rv;
      wait_c <= next_wait_c;
      src_d1 <= next_src_d1;
      src_d2 <= next_src_d2;
    end
  end

  // Pin drive: destination word in wait 0, FIFO pop at the merge in wait 2.
  assign link.control_load_strobe = st == ST_CTRL;
  assign link.dq_ctl = st == ST_CTRL ? ctrl_word : (st == ST_SRC ? src_data : dst_data);
  assign link.dq_ctl_oe = st == ST_CTRL || st == ST_SRC || (st == ST_DST && wait_c == 3'h0);
  assign link.data_latch_en = st == ST_SRC || (st == ST_DST && wait_c == 3'h0);
  assign link.source_enable = st == ST_SRC;
  assign link.word_swap_select = right_to_left;
  assign link.output_source_select = st == ST_OUT;
  assign link.line_mode = cmd == rop_pkg::ROP_CMD_LINE;
  // Block mode: FIFO read, FIFO write, right mask on the last word, left mask on the first.
  // Line mode: the right mask nibble, unused there, doubles as the pixel address.
  assign link.pixel_address_lines = cmd == rop_pkg::ROP_CMD_LINE ? ctrl_word[3:0] : {
    (st == ST_DST && wait_c == 3'h2) || (st == ST_OUT && wait_c == 3'h1),
    src_d2 || (st == ST_DST && wait_c == 3'h2 && cmd == rop_pkg::ROP_CMD_SEQ2),
    st == ST_DST && last_word,
    st == ST_DST && cnt == 5'h00};
  // In line mode the first pixel of the source word is the pixel operand.
  assign link.pixel_latch_en = st == ST_SRC && cmd == rop_pkg::ROP_CMD_LINE;
  assign link.pixel_data_ctl = src_data[15];
  assign link.fifo_clear = st == ST_IDLE && start;
  assign busy = st != ST_IDLE;
  assign result_valid = rv;
  assign result = res;
endmodule // rop_controller
`default_nettype wire

// ---- rop_datapath.sv ----
// Raster operation datapath: latches, barrel shifter, FIFO and logic unit.
`timescale 1ns/1ps
`default_nettype none
`include "rop_cfg.svh"

module rop_datapath #(
  parameter int DEPTH = `ROP_FIFO_DEPTH
) (
  // Clock and reset.
  input  wire logic clk,
  input  wire logic srst,
  // Link to the controller.
  rop_link_if.dev   link,
  // Status for observation.
  output logic [4:0] fifo_count,
  output logic [15:0] control_word
);
  localparam int AW = $clog2(DEPTH);

  // =====================================================================
  // State.
  logic [15:0] master_input_latch, next_master_input_latch;
  logic        master_is_src, next_master_is_src;
  logic        master_valid, next_master_valid;
  logic [15:0] source_input_latch, next_source_input_latch;
  logic [15:0] barrel_pipeline_latch, next_barrel_pipeline_latch;
  logic [15:0] dest_input_latch, next_dest_input_latch;
  logic        pixel_input_latch, next_pixel_input_latch;
  logic [15:0] raster_op_control, next_raster_op_control;
  logic        shift_due, next_shift_due;
  logic [15:0] fifo_mem [DEPTH];
  logic [AW-1:0] wr_ptr, next_wr_ptr;
  logic [AW-1:0] rd_ptr, next_rd_ptr;
  logic [4:0]  count, next_count;
  logic [15:0] dq_out, next_dq_out;
  logic        pix_out, next_pix_out;

  // Combinational terms.
  logic [3:0]  function_select_field;
  logic [3:0]  shift_count_field;
  logic [3:0]  left_mask_field;
  logic [3:0]  right_mask_field;
  logic [31:0] barrel_in;
  logic [15:0] shifted;
  logic [15:0] operand_s;
  logic [15:0] lu_result;
  logic [15:0] lmask;
  logic [15:0] rmask;
  logic [15:0] eff_mask;
  logic [15:0] written;
  logic        left_en, right_en, fifo_wr, fifo_rd;
  logic        do_push, do_pop;
  logic [15:0] push_data;
  logic [15:0] fifo_head;

  // =====================================================================
  // Control fields, most to least significant nibble.
  assign function_select_field = raster_op_control[`ROP_FS_MSB:`ROP_FS_LSB];
  assign shift_count_field     = raster_op_control[`ROP_SN_MSB:`ROP_SN_LSB];
  assign left_mask_field       = raster_op_control[`ROP_LM_MSB:`ROP_LM_LSB];
  assign right_mask_field      = raster_op_control[`ROP_RM_MSB:`ROP_RM_LSB];

  // Pixel address lines double as mask enables and FIFO strobes in block mode.
  assign left_en  = !link.line_mode && link.pixel_address_lines[0];
  assign right_en = !link.line_mode && link.pixel_address_lines[1];
  assign fifo_wr  = !link.line_mode && link.pixel_address_lines[2];
  assign fifo_rd  = !link.line_mode && link.pixel_address_lines[3];

  // Word swap ahead of the shifter lets the controller walk right to left.
  assign barrel_in = link.word_swap_select ? {source_input_latch, barrel_pipeline_latch}
                                           : {barrel_pipeline_latch, source_input_latch};
  // Shift i: low 16-i bits of the upper word, then top i bits of the lower.
  assign shifted = 16'(barrel_in << shift_count_field >> 16);

  // Masks: a zero marks a destination bit that is preserved.
  assign lmask = 16'hffff >> left_mask_field;
  assign rmask = ~(16'h7fff >> right_mask_field);
  assign eff_mask = (left_en ? lmask : 16'hffff) & (right_en ? rmask : 16'hffff);

  assign fifo_head = fifo_mem[rd_ptr];
  // Second operand: FIFO in block mode, replicated pixel in line mode.
  assign operand_s = link.line_mode ? {16{pixel_input_latch}} : fifo_head;

  // Per-bit lookup into the function code.
  generate
    for (genvar b = 0; b < 16; b++) begin : g_lu
      assign lu_result[b] = function_select_field[{operand_s[b], dest_input_latch[b]}];
    end
  endgenerate
  assign written = (lu_result & eff_mask) | (dest_input_latch & ~eff_mask);

  // FIFO traffic: a pending shifted word beats a result store; both never clash
  // because source loads and destination cycles are separate by protocol.
  assign do_pop  = fifo_rd && count != 5'h00;
  assign do_push = fifo_wr && (count != 5'(DEPTH) || do_pop);
  assign push_data = shift_due ? shifted : written;

  // =====================================================================
  // Next-state logic for latches, FIFO pointers and outputs.
  always_comb begin
    next_master_input_latch    = master_input_latch;
    next_master_is_src         = master_is_src;
    next_master_valid          = 1'b0;
    next_source_input_latch    = source_input_latch;
    next_barrel_pipeline_latch = barrel_pipeline_latch;
    next_dest_input_latch      = dest_input_latch;
    next_pixel_input_latch     = pixel_input_latch;
    next_raster_op_control     = raster_op_control;
    next_shift_due             = 1'b0;
    next_wr_ptr                = wr_ptr;
    next_rd_ptr                = rd_ptr;
    next_count                 = count;
    // Every source and destination bus word is first caught in the master latch.
    if (link.data_latch_en) begin
      next_master_input_latch = link.dq_ctl;
      next_master_is_src      = link.source_enable;
      next_master_valid       = 1'b1;
    end
    if (link.control_load_strobe) begin
      next_raster_op_control = link.dq_ctl;
    end
    // Route the master word to the source or destination path.
    if (master_valid && master_is_src) begin
      next_source_input_latch    = master_input_latch;
      next_barrel_pipeline_latch = source_input_latch;
      next_shift_due             = 1'b1;
    end else if (master_valid) begin
      next_dest_input_latch = master_input_latch;
    end
    if (link.pixel_latch_en) begin
      next_pixel_input_latch = link.pixel_data_ctl;
    end
    if (do_push) begin
      next_wr_ptr = AW'(wr_ptr + 1'b1);
    end
    if (do_pop) begin
      next_rd_ptr = AW'(rd_ptr + 1'b1);
    end
    next_count = 5'(count + {4'h0, do_push} - {4'h0, do_pop});
    // Clearing the FIFO counters leaves the stored words untouched.
    if (link.fifo_clear) begin
      next_wr_ptr = '0;
      next_rd_ptr = '0;
      next_count  = 5'h00;
    end
    // Output mux: FIFO head or the masked result.
    next_dq_out  = link.output_source_select ? fifo_head : written;
    next_pix_out = lu_result[link.pixel_address_lines];
  end

  // FIFO storage write.
  always_ff @(posedge clk) begin
    if (do_push) begin
      fifo_mem[wr_ptr] <= push_data;
    end
  end

  // Register stage.
  always_ff @(posedge clk) begin
    if (srst) begin
      master_input_latch    <= 16'h0000;
      master_is_src         <= 1'b0;
      master_valid          <= 1'b0;
      source_input_latch    <= 16'h0000;
      barrel_pipeline_latch <= 16'h0000;
      dest_input_latch      <= 16'h0000;
      pixel_input_latch     <= 1'b0;
      raster_op_control     <= `ROP_CTRL_RESET;
      shift_due             <= 1'b0;
      wr_ptr                <= '0;
      rd_ptr                <= '0;
      count                 <= 5'h00;
      dq_out                <= 16'h0000;
      pix_out               <= 1'b0;
    end else begin
      master_input_latch    <= next_master_input_latch;
      master_is_src         <= next_master_is_src;
      master_valid          <= next_master_valid;
      source_input_latch    <= next_source_input_latch;
      barrel_pipeline_latch <= next_barrel_pipeline_latch;
      dest_input_latch      <= next_dest_input_latch;
      pixel_input_latch     <= next_pixel_input_latch;
      raster_op_control     <= next_raster_op_control;
      shift_due             <= next_shift_due;
      wr_ptr                <= next_wr_ptr;
      rd_ptr                <= next_rd_ptr;
      count                 <= next_count;
      dq_out                <= next_dq_out;
      pix_out               <= next_pix_out;
    end
  end

  // Bus drive: the device drives data only when the controller is not.
  assign link.dq_dev         = dq_out;
  assign link.dq_dev_oe      = !link.dq_ctl_oe;
  assign link.pixel_data_pin = pix_out;
  assign fifo_count          = count;
  assign control_word        = raster_op_control;
endmodule // rop_datapath
`default_nettype wire

// ---- rop_link_checker.sv ----
// Concurrent checks on the link between the raster operation datapath and its controller.
`timescale 1ns/1ps
`default_nettype none
module rop_link_checker (
  // Clock and reset.
  input wire logic        clk,
  input wire logic        srst,
  // Link signals.
  input wire logic [15:0] dq_ctl,
  input wire logic        dq_ctl_oe,
  input wire logic        dq_dev_oe,
  input wire logic        control_load_strobe,
  input wire logic        data_latch_en,
  input wire logic        line_mode,
  input wire logic [3:0]  pixel_address_lines,
  input wire logic        fifo_clear,
  // Datapath status.
  input wire logic [4:0]  fifo_count,
  input wire logic [15:0] control_word
);
  logic loaded;
  logic next_loaded;
  logic push_only;
  logic pop_only;

  // =====================================================================
  // Helper state.
  // Remembers a control load since reset, so data traffic can be ordered after it.
  always_comb begin
    next_loaded = loaded | control_load_strobe;
  end
  always_ff @(posedge clk) begin
    if (srst) begin
      loaded <= 1'b0;
    end else begin
      loaded <= next_loaded;
    end
  end
  // FIFO strobes only count in block mode; simultaneous read and write is left out.
  assign push_only = !line_mode & pixel_address_lines[2] & !pixel_address_lines[3] & !fifo_clear;
  assign pop_only  = !line_mode & pixel_address_lines[3] & !pixel_address_lines[2] & !fifo_clear;

  // =====================================================================
  // Assertions.
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (srst);

  bus_single_driver_a: assert property (!(dq_dev_oe && dq_ctl_oe))
    else $error("Both ends drive the data bus");
  ctrl_drive_a: assert property (control_load_strobe |-> dq_ctl_oe)
    else $error("Control load without the controller driving the bus");
  ctrl_load_a: assert property (control_load_strobe |=> control_word == $past(dq_ctl))
    else $error("Control word does not hold the loaded bus value");
  load_order_a: assert property (data_latch_en |-> loaded)
    else $error("Data latched before any control load");
  reset_value_a: assert property ($fell(srst) |-> control_word == 16'h000f && fifo_count == 5'h00)
    else $error("Wrong state after reset");
  fifo_cap_a: assert property (fifo_count <= 5'h10)
    else $error("FIFO holds more than sixteen words");
  fifo_push_a: assert property (push_only && fifo_count < 5'h10 |=>
      fifo_count == $past(fifo_count) + 5'h01)
    else $error("FIFO push not counted");
  fifo_full_a: assert property (push_only && fifo_count == 5'h10 |=> fifo_count == 5'h10)
    else $error("Push into full FIFO changed the count");
  fifo_pop_a: assert property (pop_only && fifo_count != 5'h00 |=>
      fifo_count == $past(fifo_count) - 5'h01)
    else $error("FIFO pop not counted");
endmodule // rop_link_checker
`default_nettype wire

// ---- rop_link_if.sv ----
// Interface joining the raster operation datapath and its controller.
`timescale 1ns/1ps
`default_nettype none
interface rop_link_if;
  logic [15:0] dq_ctl;        // Data bus driven by the controller.
  logic        dq_ctl_oe;
  logic [15:0] dq_dev;        // Data bus driven by the datapath.
  logic        dq_dev_oe;
  logic        control_load_strobe;
  logic        data_latch_en;
  logic        source_enable;
  logic        word_swap_select;
  logic        output_source_select;
  logic        line_mode;
  logic [3:0]  pixel_address_lines;  // Masks/FIFO strobes in block mode.
  logic        pixel_latch_en;
  logic        pixel_data_ctl;
  logic        pixel_data_pin;
  logic        fifo_clear;
  modport dev (
    input  dq_ctl, dq_ctl_oe, control_load_strobe, data_latch_en, source_enable,
           word_swap_select, output_source_select, line_mode, pixel_address_lines,
           pixel_latch_en, pixel_data_ctl, fifo_clear,
    output dq_dev, dq_dev_oe, pixel_data_pin
  );
  modport ctl (
    output dq_ctl, dq_ctl_oe, control_load_strobe, data_latch_en, source_enable,
           word_swap_select, output_source_select, line_mode, pixel_address_lines,
           pixel_latch_en, pixel_data_ctl, fifo_clear,
    input  dq_dev, dq_dev_oe, pixel_data_pin
  );
endinterface
`default_nettype wire

// ---- rop_pkg.sv ----
// Types shared by the controller end of the raster operation link and the testbench.
package rop_pkg;
  // Controller command codes.
  typedef enum logic [1:0] {
    ROP_CMD_SEQ1,
    ROP_CMD_SEQ2,
    ROP_CMD_LINE
  } rop_cmd_t;
endpackage
